// ==== hw/psr_pkg.sv ====
package psr_pkg;

   // Register word indices and their byte addresses (byte address is four times the index)
   localparam logic [11:0] PSR_IDX_STATUS  = 12'h01f;
   localparam logic [11:0] PSR_IDX_MONCFG  = 12'h01a;
   localparam logic [11:0] PSR_ADDR_STATUS = 12'h07c;
   localparam logic [11:0] PSR_ADDR_MONCFG = 12'h068;
   localparam logic [11:0] PSR_ADDR_IRQ_ST = 12'h100;
   localparam logic [11:0] PSR_ADDR_IRQ_MK = 12'h104;

   // Status bit positions, and the threshold select bit of the monitor config register
   localparam int PSR_BIT_LOCK     = 0;
   localparam int PSR_BIT_PRI_FREQ = 1;
   localparam int PSR_BIT_SEC_FREQ = 2;
   localparam int PSR_BIT_EXT_FREQ = 3;
   localparam int PSR_BIT_SEC_SEL  = 4;
   localparam int PSR_BIT_HOLDOVER = 5;
   localparam int PSR_BIT_THR_SEL  = 6;
   localparam int PSR_NUM_SRC      = 6;

   // Reset values
   localparam logic [7:0]  PSR_RST_BYTE = 8'h00;
   localparam logic [31:0] PSR_RST_WORD = 32'h0000_0000;

   // Raw status sources
   typedef struct packed {
      logic holdover;
      logic sec_sel;
      logic ext_freq;
      logic sec_freq;
      logic pri_freq;
      logic lock;
   } psr_src_s;

   // APB request bundle
   typedef struct packed {
      logic        sel;
      logic        enable;
      logic        write;
      logic [11:0] addr;
      logic [31:0] wdata;
   } psr_apb_req_s;

endpackage : psr_pkg

// ==== hw/psr_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module psr_sync
   import psr_pkg::*;
(
   // Clock and reset
   input  wire logic             i_clk_sys,
   input  wire logic             i_rst,
   // Raw and synchronised sources
   input  wire logic [5:0]       i_raw,
   output logic      [5:0]       o_sync
);
   logic [5:0] meta_r;
   logic [5:0] sync_r;

   // Two-stage synchroniser per bit; monitors run on other clocks
   genvar g;
   generate
      for (g = 0; g < PSR_NUM_SRC; g++) begin : g_bit
         always_ff @(posedge i_clk_sys) begin
            if (i_rst) begin
               meta_r[g] <= 1'b0;
               sync_r[g] <= 1'b0;
            end else begin
               meta_r[g] <= i_raw[g];
               sync_r[g] <= meta_r[g];
            end
         end
      end
   endgenerate

   assign o_sync = sync_r;
endmodule : psr_sync
`default_nettype wire

// ==== hw/psr_irq.sv ====
`timescale 1ns/1ps
`default_nettype none
module psr_irq
   import psr_pkg::*;
(
   // Clock and reset
   input  wire logic             i_clk_sys,
   input  wire logic             i_rst,
   // Event and software controls
   input  wire logic [5:0]       i_event,
   input  wire logic             i_clr_we,
   input  wire logic [5:0]       i_clr_data,
   input  wire logic             i_mask_we,
   input  wire logic [5:0]       i_mask_data,
   // State
   output logic      [5:0]       o_status,
   output logic      [5:0]       o_mask,
   output logic                  o_irq
);
   logic [5:0] status_r;
   logic [5:0] status_nxt;
   logic [5:0] mask_r;
   logic       irq_r;
   wire  [5:0] clr_bits = i_clr_we ? i_clr_data : 6'h00;

   // Set wins over write-one-to-clear so no edge is lost
   assign status_nxt = (status_r & ~clr_bits) | i_event;

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         status_r <= 6'h00;
         mask_r   <= 6'h00;
         irq_r    <= 1'b0;
      end else begin
         status_r <= status_nxt;
         if (i_mask_we) mask_r <= i_mask_data;
         irq_r    <= |(status_nxt & mask_r);
      end
   end

   assign o_status = status_r;
   assign o_mask   = mask_r;
   assign o_irq    = irq_r;
endmodule : psr_irq
`default_nettype wire

// ==== hw/psr_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module psr_top
   import psr_pkg::*;
(
   // Clock and reset
   input  wire logic             i_clk_sys,
   input  wire logic             i_rst,
   // APB slave
   input  wire logic             i_psel,
   input  wire logic             i_penable,
   input  wire logic             i_pwrite,
   input  wire logic [11:0]      i_paddr,
   input  wire logic [31:0]      i_pwdata,
   output logic                  o_pready,
   output logic      [31:0]      o_prdata,
   output logic                  o_pslverr,
   // Status sources from holdover, switchover, monitors, lock detector
   input  wire logic             i_holdover_active,
   input  wire logic             i_secondary_selected,
   input  wire logic             i_ext_clk_above_thr,
   input  wire logic             i_secondary_above_thr,
   input  wire logic             i_primary_above_thr,
   input  wire logic             i_digital_lock,
   // Monitor threshold select and interrupt
   output logic                  o_ref_thr_sel,
   output logic                  o_irq
);
   psr_apb_req_s req;
   psr_src_s     raw_src;
   logic [5:0]   live;
   logic [5:0]   live_d_r;
   logic [5:0]   irq_status;
   logic [5:0]   irq_mask;
   logic         irq_w;
   logic         thr_sel_r;
   logic         pready_r;
   logic [31:0]  prdata_r;
   logic         pslverr_r;

   assign req = '{sel: i_psel, enable: i_penable, write: i_pwrite, addr: i_paddr, wdata: i_pwdata};

   // Bits fed straight from their sources; holdover is the state, not the enable
   assign raw_src.holdover = i_holdover_active;
   assign raw_src.sec_sel  = i_secondary_selected;
   assign raw_src.ext_freq = i_ext_clk_above_thr;
   assign raw_src.sec_freq = i_secondary_above_thr;
   assign raw_src.pri_freq = i_primary_above_thr;
   assign raw_src.lock     = i_digital_lock;

   // Sources come from foreign clocks, so each is synchronised
   psr_sync u_sync (
      .i_clk_sys (i_clk_sys),
      .i_rst     (i_rst),
      .i_raw     (raw_src),
      .o_sync    (live)
   );

   // Any change of a status bit is an event
   wire [5:0] change_evt = live ^ live_d_r;

   // Register decode; reads taken in setup phase and answered at next edge, writes in access phase
   wire setup     = req.sel & ~req.enable;
   wire hit_stat  = req.addr == PSR_ADDR_STATUS;
   wire hit_cfg   = req.addr == PSR_ADDR_MONCFG;
   wire hit_ist   = req.addr == PSR_ADDR_IRQ_ST;
   wire hit_imk   = req.addr == PSR_ADDR_IRQ_MK;
   wire mapped    = hit_stat | hit_cfg | hit_ist | hit_imk;
   wire acc_phase = req.sel & req.enable & pready_r;
   wire wr_cfg    = acc_phase & req.write & hit_cfg;
   wire wr_ist    = acc_phase & req.write & hit_ist;
   wire wr_imk    = acc_phase & req.write & hit_imk;

   // Status read is the live synchronised state, write has no effect
   wire [31:0] rd_mux = hit_stat ? {26'h0, live} :
                        hit_cfg  ? {25'h0, thr_sel_r, 6'h00} :
                        hit_ist  ? {26'h0, irq_status} :
                        hit_imk  ? {26'h0, irq_mask} : PSR_RST_WORD;

   psr_irq u_irq (
      .i_clk_sys   (i_clk_sys),
      .i_rst       (i_rst),
      .i_event     (change_evt),
      .i_clr_we    (wr_ist),
      .i_clr_data  (req.wdata[5:0]),
      .i_mask_we   (wr_imk),
      .i_mask_data (req.wdata[5:0]),
      .o_status    (irq_status),
      .o_mask      (irq_mask),
      .o_irq       (irq_w)
   );

   // Bus response: one wait-free access phase; unmapped gives pslverr
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         pready_r  <= 1'b0;
         prdata_r  <= PSR_RST_WORD;
         pslverr_r <= 1'b0;
         thr_sel_r <= 1'b0;
         live_d_r  <= 6'h00;
      end else begin
         pready_r  <= setup;
         pslverr_r <= setup & ~mapped;
         if (setup) prdata_r <= (req.write | ~mapped) ? PSR_RST_WORD : rd_mux;
         if (wr_cfg) thr_sel_r <= req.wdata[PSR_BIT_THR_SEL];
         live_d_r  <= live;
      end
   end

   assign o_pready      = pready_r;
   assign o_prdata      = prdata_r;
   assign o_pslverr     = pslverr_r;
   assign o_ref_thr_sel = thr_sel_r;
   assign o_irq         = irq_w;
endmodule : psr_top
`default_nettype wire

// ==== dv/psr_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
module psr_chk
   import psr_pkg::*;
(
   // Clock, reset and bus
   input wire logic        i_clk_sys,
   input wire logic        i_rst,
   input wire logic        i_psel,
   input wire logic        i_penable,
   input wire logic        i_pwrite,
   input wire logic [11:0] i_paddr,
   input wire logic        o_pready,
   input wire logic [31:0] o_prdata,
   // Status sources
   input wire logic        i_holdover_active,
   input wire logic        i_secondary_selected,
   input wire logic        i_ext_clk_above_thr,
   input wire logic        i_secondary_above_thr,
   input wire logic        i_primary_above_thr,
   input wire logic        i_digital_lock
);
   logic [5:0] src_q_r;
   logic [2:0] stc_r;
   wire  [5:0] src = {i_holdover_active, i_secondary_selected, i_ext_clk_above_thr,
                      i_secondary_above_thr, i_primary_above_thr, i_digital_lock};
   // Only judge reads once sources sat still past the synchroniser delay
   wire        rd = o_pready && !i_pwrite && i_paddr == PSR_ADDR_STATUS && stc_r >= 3'h5;
   // Cycles since the sources last moved, saturating
   always_ff @(posedge i_clk_sys) begin
      src_q_r <= src;
      stc_r   <= (i_rst || src != src_q_r) ? 3'h0 : (stc_r == 3'h7 ? stc_r : stc_r + 3'h1);
   end
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (i_rst);
   chk_lock_bit:
      assert property (rd |-> o_prdata[PSR_BIT_LOCK] == i_digital_lock) else $error("lock bit wrong");
   chk_pri_freq:
      assert property (rd |-> o_prdata[PSR_BIT_PRI_FREQ] == i_primary_above_thr) else $error("pri bit wrong");
   chk_sec_freq:
      assert property (rd |-> o_prdata[PSR_BIT_SEC_FREQ] == i_secondary_above_thr) else $error("sec bit wrong");
   chk_ext_freq:
      assert property (rd |-> o_prdata[PSR_BIT_EXT_FREQ] == i_ext_clk_above_thr) else $error("ext bit wrong");
   chk_ref_sel:
      assert property (rd |-> o_prdata[PSR_BIT_SEC_SEL] == i_secondary_selected) else $error("sel bit wrong");
   chk_holdover_bit:
      assert property (rd |-> o_prdata[PSR_BIT_HOLDOVER] == i_holdover_active) else $error("hold bit wrong");
   chk_upper_zero:
      assert property (rd |-> o_prdata[31:6] == 26'h0) else $error("upper bits set");
   chk_read_answer:
      assert property (i_psel && !i_penable |=> o_pready ##1 !o_pready) else $error("no answer");
endmodule : psr_chk
bind psr_top psr_chk i_chk (.i_clk_sys, .i_rst, .i_psel, .i_penable, .i_pwrite, .i_paddr, .o_pready,
   .o_prdata, .i_holdover_active, .i_secondary_selected, .i_ext_clk_above_thr,
   .i_secondary_above_thr, .i_primary_above_thr, .i_digital_lock);
`default_nettype wire

// ==== dv/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench
   import psr_pkg::*;
;
   logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
   logic [11:0] pa = 12'h0;
   logic [31:0] pwd = 32'h0, q, prdata;
   logic        e, pready, pslverr, thr, irq;
   psr_src_s    src = 6'h0;
   int          errors = 0, total_checks = 0, cyc = 0, i;
   // Clock at 4 ns
   always #2 clk = ~clk;
   psr_top i_dut (.i_clk_sys(clk), .i_rst(rst), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
      .i_paddr(pa), .i_pwdata(pwd), .o_pready(pready), .o_prdata(prdata), .o_pslverr(pslverr),
      .i_holdover_active(src.holdover), .i_secondary_selected(src.sec_sel),
      .i_ext_clk_above_thr(src.ext_freq), .i_secondary_above_thr(src.sec_freq),
      .i_primary_above_thr(src.pri_freq), .i_digital_lock(src.lock), .o_ref_thr_sel(thr), .o_irq(irq));
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         errors++;
         $display("BAD %0t got %h exp %h", $time, seen, exp);
      end
   endtask : chk
   // One APB transfer, entered and left just after a rising edge; pready and data are taken at the
   // rising edge itself, where the registered outputs still show the access-phase values
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pen  <= 1'b0;
      pwr  <= w;
      pa   <= a;
      pwd  <= d;
      @(posedge clk);
      pen <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1 && n < 20) begin
         @(posedge clk);
         n++;
      end
      if (n == 20) errors++;
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      pen  <= 1'b0;
      // Let one idle edge pass so the next call never re-raises psel in this time step
      @(posedge clk);
   endtask : apb
   task rd(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(q, exp);
   endtask : rd
   task complete_run;
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : complete_run
   // Hang guard, far above the roughly 110 cycles the tests need
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         errors++;
         complete_run;
      end
   end
   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      rd(PSR_ADDR_STATUS, PSR_RST_WORD);
      rd(PSR_ADDR_IRQ_MK, 32'h0);
      $display("reset test done");
      // Each source alone, then all, then a write that must not stick
      for (i = 0; i <= PSR_NUM_SRC; i++) begin
         src <= (i == PSR_NUM_SRC) ? 6'h3f : 6'h01 << i;
         repeat (6) @(posedge clk);
         rd(PSR_ADDR_STATUS, (i == PSR_NUM_SRC) ? 32'h3f : 32'h1 << i);
      end
      apb(1'b1, PSR_ADDR_STATUS, 32'h0);
      rd(PSR_ADDR_STATUS, 32'h3f);
      $display("status test done");
      apb(1'b1, PSR_ADDR_MONCFG, 32'h40);
      rd(PSR_ADDR_MONCFG, 32'h40);
      chk({31'h0, thr}, 32'h1);
      apb(1'b0, 12'h200, 32'h0);
      chk(q, 32'h0);
      chk({31'h0, e}, 32'h1);
      $display("config test done");
      // Every source changed, so all sticky bits set while masked
      rd(PSR_ADDR_IRQ_ST, 32'h3f);
      chk({31'h0, irq}, 32'h0);
      apb(1'b1, PSR_ADDR_IRQ_MK, 32'h01);
      repeat (2) @(negedge clk);
      chk({31'h0, irq}, 32'h1);
      apb(1'b1, PSR_ADDR_IRQ_ST, 32'h3f);
      rd(PSR_ADDR_IRQ_ST, 32'h0);
      chk({31'h0, irq}, 32'h0);
      $display("irq test done");
      complete_run;
   end
endmodule : testbench
`default_nettype wire
